// ### inc/bbrc_pkg.sv
// constants and state type of the backlight brightness ramp control block
`default_nettype none
package bbrc_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] BOOST_CONFIG_ADDR   = 8'h13;
   localparam logic [7:0] STRING_ENABLE_ADDR  = 8'h14;
   localparam logic [7:0] SLOPE_CONFIG_ADDR   = 8'h15;
   localparam logic [7:0] RAMP_STATUS_ADDR    = 8'h1e;   // read-only state view
   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] STRING_ENABLE_RST   = 8'h00;
   localparam logic [7:0] SLOPE_CONFIG_RST    = 8'h00;
   localparam int         FREQ_BIT            = 0;       // boost_switch_freq_select
   localparam int         INDUCTOR_BIT        = 1;       // inductor range select
   localparam int         OV_LSB              = 6;       // string_overvoltage_level
   localparam int         SMOOTHING_STRENGTH_LSB          = 6;       // smoothing_strength
   localparam int         HYST_LSB            = 3;       // duty_input_hysteresis code
   localparam int         SLOPE_LSB           = 0;       // linear slope time code
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ             = 20_000_000;
   localparam int unsigned RAMP_STEPS         = 4096;     // steps of one linear ramp
   // slope times in microseconds, code 000 .. 111
   localparam int unsigned SLOPE_US [8] = '{0, 8000, 16000, 24000, 28000, 32000,
                                            100000, 200000};
   // cycles per ramp step, rounded down
   localparam logic [9:0] STEP_CYC [8] = '{
      10'(SLOPE_US[0] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[1] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[2] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[3] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[4] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[5] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[6] * (CLK_HZ / 1_000_000) / RAMP_STEPS),
      10'(SLOPE_US[7] * (CLK_HZ / 1_000_000) / RAMP_STEPS)};
   localparam logic [9:0] FLT_BASE_CYC        = 10'h004;  // filter tick with no slope
   localparam logic [15:0] PER_MAX            = 16'hffff; // stuck-input limit
   localparam logic [3:0]  DIV_STEPS          = 4'hc;     // quotient bits
   localparam logic [12:0] POS_END            = 13'h1000;
   localparam int          FRAC_BITS          = 8;        // filter fraction bits
   // ----------------------------------------------------------------
   // state of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  boost;      // boost_config
      logic        freq_act;   // frequency select in force
      logic [7:0]  string_enable_bank_a;      // string_enable_bank_a
      logic [7:0]  slope;      // brightness_slope_config
      logic        pwm_s1;     // synchroniser stages
      logic        pwm_s2;
      logic        pwm_d;      // edge detect delay
      logic [15:0] per_cnt;    // samples in present period
      logic [15:0] hi_cnt;     // high samples in present period
      logic [15:0] div_den;
      logic [16:0] div_rem;
      logic [11:0] div_q;
      logic [3:0]  div_n;
      logic        div_busy;
      logic [11:0] duty_app;   // applied duty value
      logic [11:0] lin_start;
      logic [11:0] lin_tgt;
      logic [11:0] lin_out;
      logic [12:0] pos;
      logic [9:0]  stepc;
      logic        ramping;
      logic [19:0] flt;        // smoothed level with fraction
      logic [5:0]  removed;
      logic [5:0]  drive;
      logic [11:0] bright;
      logic [7:0]  rdata;
   } bbrc_state_t;
endpackage
`default_nettype wire

// ### logic/bbrc_top.sv
// configuration registers, duty detector and brightness ramp of the backlight driver
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE_01: frequency select acts only from nonvolatile default
// RULE_02: inductor range bit drives boost logic
// RULE_03: two-bit overvoltage level threshold output
// RULE_04: disabled string is never driven
// RULE_05: no auto-detect: enabled strings stay on
// RULE_06: auto-detect removes faulted strings
// RULE_07: smoothing strength selects RC-like filter
// RULE_08: slope code selects linear ramp time
// RULE_09: ramp time independent of distance
// RULE_10: filter rate scales with slope time
// RULE_11: PWM input oversampled on 20 MHz clock
// RULE_12: duty measured to at most 12 bits
// RULE_13: precision halves per input frequency doubling
// RULE_14: duty applied only beyond hysteresis
// RULE_15: hysteresis code selects threshold steps
// RULE_16: total ramp follows slope and smoothing
// RULE_17: source select picks smoothed path
// RULE_18: new target restarts ramp from present level
module bbrc_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // register port from the serial interface core
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   output var  logic [7:0]  reg_rdata,
   // nonvolatile default and device control
   input  wire logic [7:0]  nv_boost_config,
   input  wire logic [1:0]  brightness_source_select,
   input  wire logic [11:0] reg_brightness,
   input  wire logic        backlight_on,
   input  wire logic        auto_detect,
   input  wire logic [5:0]  string_fault,
   // external pwm brightness pin
   input  wire logic        pwm_in,
   // outputs to boost, sinks and dimming
   output var  logic        boost_switch_freq_select,
   output var  logic        inductor_range,
   output var  logic [1:0]  string_overvoltage_level,
   output var  logic [5:0]  string_drive,
   output var  logic [11:0] duty_value,
   output var  logic [11:0] brightness_level,
   output var  logic        ramp_busy
);
   // ----------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------
   bbrc_pkg::bbrc_state_t st_r;        // registered state
   bbrc_pkg::bbrc_state_t st_nxt;      // next state
   logic [2:0]  slope_code;            // linear slope time code
   logic [1:0]  smoothing_strength_code;           // smoothing_strength
   logic [2:0]  hyst_code;             // duty_input_hysteresis
   logic [9:0]  tick_cyc;              // cycles per step or filter tick
   logic        tick;                  // one step or filter tick
   logic [11:0] tgt_src;               // level the ramp heads for
   logic        cand_vld;              // new measured duty value
   logic [11:0] cand;

   assign slope_code  = st_r.slope[bbrc_pkg::SLOPE_LSB +: 3];
   assign smoothing_strength_code = st_r.slope[bbrc_pkg::SMOOTHING_STRENGTH_LSB +: 2];
   assign hyst_code   = st_r.slope[bbrc_pkg::HYST_LSB +: 3];

   // threshold test: true when the new value moves far enough
   function automatic logic hyst_pass(input logic [11:0] nv, input logic [11:0] ov,
                                      input logic [2:0] code);
      logic [11:0] diff;
      logic [11:0] thr;
      diff = (nv > ov) ? nv - ov : ov - nv;
      thr  = (code == 3'h0) ? 12'h000 : 12'(12'h001 << (code - 3'h1));
      return diff > thr;
   endfunction

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [24:0] prod;
      logic [12:0] span;
      logic [11:0] delta;
      logic [20:0] fdiff;
      logic [19:0] fstep;
      logic [23:0] mix;
      logic [16:0] rsh;
      st_nxt = st_r;
      prod   = '0;
      span   = '0;
      delta  = '0;
      fdiff  = '0;
      fstep  = '0;
      mix    = '0;
      rsh    = '0;
      cand_vld = 1'b0;
      cand     = st_r.duty_app;
      // filter follows slope time; a bare tick keeps code 000 usable
      tick_cyc = (slope_code == 3'h0) ? bbrc_pkg::FLT_BASE_CYC
                                      : bbrc_pkg::STEP_CYC[slope_code];   // see RULE_10
      tick     = (st_r.stepc == tick_cyc - 10'h001);
      tgt_src  = (brightness_source_select == 2'b10) ? st_r.duty_app
                                                     : reg_brightness;  // see RULE_17

      // register writes; frequency bit is stored but never put in force
      if (reg_wr) begin
         unique case (reg_addr)
            bbrc_pkg::BOOST_CONFIG_ADDR:  st_nxt.boost = reg_wdata;     // see RULE_01
            bbrc_pkg::STRING_ENABLE_ADDR: st_nxt.string_enable_bank_a = reg_wdata;
            bbrc_pkg::SLOPE_CONFIG_ADDR:  st_nxt.slope = reg_wdata;
            default: ;                                   // unmapped writes dropped
         endcase
      end
      // read data, unmapped reads zero
      unique case (reg_addr)
         bbrc_pkg::BOOST_CONFIG_ADDR:  st_nxt.rdata = st_r.boost;
         bbrc_pkg::STRING_ENABLE_ADDR: st_nxt.rdata = st_r.string_enable_bank_a;
         bbrc_pkg::SLOPE_CONFIG_ADDR:  st_nxt.rdata = st_r.slope;
         bbrc_pkg::RAMP_STATUS_ADDR:   st_nxt.rdata = {st_r.ramping, 1'b0, st_r.removed};
         default:                      st_nxt.rdata = 8'h00;
      endcase

      // string control: removed set wins, cleared only with backlight off
      if (backlight_on) begin
         if (auto_detect) begin
            st_nxt.removed = st_r.removed | (string_fault & st_r.string_enable_bank_a[5:0]); // see RULE_06
         end
         st_nxt.drive = st_r.string_enable_bank_a[5:0]
                        & ~(auto_detect ? st_nxt.removed : 6'h00);  // see RULE_04 RULE_05
      end else begin
         st_nxt.removed = 6'h00;
         st_nxt.drive   = 6'h00;
      end

      // pin synchroniser and period counters on every 20 MHz sample
      st_nxt.pwm_s1 = pwm_in;                                        // see RULE_11
      st_nxt.pwm_s2 = st_r.pwm_s1;
      st_nxt.pwm_d  = st_r.pwm_s2;
      if (st_r.pwm_s2 && !st_r.pwm_d) begin
         // rising edge closes a period; fewer samples give fewer
         // meaningful quotient bits on their own
         st_nxt.per_cnt = 16'h0001;
         st_nxt.hi_cnt  = 16'h0001;
         if (st_r.per_cnt != 16'h0000) begin
            if (st_r.hi_cnt >= st_r.per_cnt) begin
               cand_vld = 1'b1;
               cand     = 12'hfff;
            end else begin
               st_nxt.div_den  = st_r.per_cnt;
               st_nxt.div_rem  = {1'b0, st_r.hi_cnt};
               st_nxt.div_q    = 12'h000;
               st_nxt.div_n    = bbrc_pkg::DIV_STEPS;
               st_nxt.div_busy = 1'b1;                   // see RULE_12 RULE_13
            end
         end
      end else if (st_r.per_cnt == bbrc_pkg::PER_MAX) begin
         // input stuck: duty is its level
         cand_vld = 1'b1;
         cand     = st_r.pwm_s2 ? 12'hfff : 12'h000;
         st_nxt.hi_cnt = 16'h0000;
      end else begin
         st_nxt.per_cnt = st_r.per_cnt + 16'h0001;
         st_nxt.hi_cnt  = st_r.hi_cnt + {15'h0000, st_r.pwm_s2};
      end

      // restoring divider, one quotient bit per cycle
      if (st_r.div_busy && !(st_r.pwm_s2 && !st_r.pwm_d)) begin
         rsh = {st_r.div_rem[15:0], 1'b0};
         if (rsh >= {1'b0, st_r.div_den}) begin
            st_nxt.div_rem = rsh - {1'b0, st_r.div_den};
            st_nxt.div_q   = {st_r.div_q[10:0], 1'b1};
         end else begin
            st_nxt.div_rem = rsh;
            st_nxt.div_q   = {st_r.div_q[10:0], 1'b0};
         end
         st_nxt.div_n = st_r.div_n - 4'h1;
         if (st_r.div_n == 4'h1) begin
            st_nxt.div_busy = 1'b0;
            cand_vld = 1'b1;
            cand     = st_nxt.div_q;
         end
      end
      // hysteresis gate on the measured value
      if (cand_vld && hyst_pass(cand, st_r.duty_app, hyst_code)) begin
         st_nxt.duty_app = cand;                                     // see RULE_14 RULE_15
      end

      // free-running tick counter
      st_nxt.stepc = tick ? 10'h000 : st_r.stepc + 10'h001;

      // linear ramp: fixed step count, so time is fixed, not distance
      if (tgt_src != st_r.lin_tgt) begin
         st_nxt.lin_start = st_r.lin_out;                            // see RULE_18
         st_nxt.lin_tgt   = tgt_src;
         st_nxt.pos       = 13'h0000;
         st_nxt.stepc     = 10'h000;
         st_nxt.ramping   = (slope_code != 3'h0);
         if (slope_code == 3'h0) begin
            st_nxt.lin_out = tgt_src;
         end
      end else if (st_r.ramping && tick) begin
         span  = st_r.pos + 13'h0001;
         delta = (st_r.lin_tgt > st_r.lin_start) ? st_r.lin_tgt - st_r.lin_start
                                                 : st_r.lin_start - st_r.lin_tgt;
         prod  = delta * span;                                       // see RULE_08 RULE_09
         st_nxt.pos = span;
         if (span == bbrc_pkg::POS_END) begin
            st_nxt.lin_out = st_r.lin_tgt;
            st_nxt.ramping = 1'b0;
         end else if (st_r.lin_tgt > st_r.lin_start) begin
            st_nxt.lin_out = st_r.lin_start + prod[23:12];
         end else begin
            st_nxt.lin_out = st_r.lin_start - prod[23:12];
         end
      end

      // rc-like smoothing behind the linear ramp
      if (smoothing_strength_code == 2'b00) begin
         st_nxt.flt = {st_r.lin_out, 8'h00};                         // see RULE_07
      end else if (tick) begin
         // shift of 2, 3 or 4; three bits wide so heavy cannot wrap to zero
         fdiff = {1'b0, st_r.lin_out, 8'h00} - {1'b0, st_r.flt};
         fstep = 20'($signed(fdiff) >>> ({1'b0, smoothing_strength_code} + 3'h1));
         // a step that rounds to nothing snaps, so the filter lands on target
         st_nxt.flt = (fstep == 20'h00000) ? {st_r.lin_out, 8'h00}
                                           : st_r.flt + fstep;         // see RULE_16
      end

      // source mixing: the other source acts at once
      unique case (brightness_source_select)
         2'b00: st_nxt.bright = st_r.duty_app;
         2'b01: st_nxt.bright = reg_brightness;
         2'b10: begin
            mix = st_r.flt[19:8] * reg_brightness;
            st_nxt.bright = mix[23:12];                              // see RULE_17
         end
         2'b11: begin
            mix = st_r.flt[19:8] * st_r.duty_app;
            st_nxt.bright = mix[23:12];
         end
      endcase

      // synchronous reset; boost byte and frequency come from nonvolatile
      if (srst) begin
         st_nxt          = '0;
         st_nxt.boost    = nv_boost_config;
         st_nxt.freq_act = nv_boost_config[bbrc_pkg::FREQ_BIT];     // see RULE_01
         st_nxt.string_enable_bank_a    = bbrc_pkg::STRING_ENABLE_RST;
         st_nxt.slope    = bbrc_pkg::SLOPE_CONFIG_RST;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   // outputs straight from state flops
   assign reg_rdata                = st_r.rdata;
   assign boost_switch_freq_select = st_r.freq_act;
   assign inductor_range           = st_r.boost[bbrc_pkg::INDUCTOR_BIT];  // see RULE_02
   assign string_overvoltage_level = st_r.string_enable_bank_a[bbrc_pkg::OV_LSB +: 2];   // see RULE_03
   assign string_drive             = st_r.drive;
   assign duty_value               = st_r.duty_app;
   assign brightness_level         = st_r.bright;
   assign ramp_busy                = st_r.ramping;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_freq_fixed: assert property ($stable(boost_switch_freq_select)) // see RULE_01
      else $error("frequency select changed at run time");
   a_inductor_write: assert property (                               // see RULE_02
      reg_wr && reg_addr == bbrc_pkg::BOOST_CONFIG_ADDR |=>
         inductor_range == $past(reg_wdata[1]))
      else $error("inductor range not taken from write");
   a_ov_write: assert property (                                     // see RULE_03
      reg_wr && reg_addr == bbrc_pkg::STRING_ENABLE_ADDR |=>
         string_overvoltage_level == $past(reg_wdata[7:6]))
      else $error("overvoltage level not taken from write");
   a_disabled_dark: assert property (                                // see RULE_04
      ##1 (string_drive & ~$past(st_r.string_enable_bank_a[5:0])) == 6'h00)
      else $error("disabled string driven");
   a_manual_hold: assert property (                                  // see RULE_05
      !auto_detect && backlight_on |=> string_drive == $past(st_r.string_enable_bank_a[5:0]))
      else $error("enabled string dropped without auto-detect");
   a_fault_remove: assert property (                                 // see RULE_06
      auto_detect && backlight_on && (string_fault != 6'h00) |=>
         (string_drive & $past(string_fault)) == 6'h00)
      else $error("faulted string kept in auto-detect");
   a_smoothing_strength_none: assert property (                                  // see RULE_07
      smoothing_strength_code == 2'b00 |=> st_r.flt[19:8] == $past(st_r.lin_out))
      else $error("filter active with no smoothing");
   a_step_period: assert property (                                  // see RULE_08
      st_r.ramping && $past(st_r.ramping) && $changed(st_r.pos) && st_r.pos != 13'h0000 |->
         $past(st_r.stepc) == $past(tick_cyc) - 10'h001)
      else $error("ramp step off its period");
   a_ramp_lands: assert property (                                   // see RULE_09
      $fell(st_r.ramping) && $stable(st_r.lin_tgt) |-> st_r.lin_out == st_r.lin_tgt)
      else $error("ramp ended off target");
   a_hyst_gate: assert property (                                    // see RULE_14
      $changed(duty_value) |->
         hyst_pass(duty_value, $past(duty_value), $past(hyst_code)))
      else $error("duty applied inside hysteresis");
   a_direct_source: assert property (                                // see RULE_17
      brightness_source_select == 2'b00 |=> brightness_level == $past(duty_value))
      else $error("direct duty source not immediate");
   a_restart_here: assert property (                                 // see RULE_18
      tgt_src != st_r.lin_tgt |=>
         st_r.pos == 13'h0000 && st_r.lin_start == $past(st_r.lin_out))
      else $error("ramp restart not from present level");

   c_ramp_done: cover property ($fell(st_r.ramping));
   c_string_removed: cover property (auto_detect && st_r.removed != 6'h00);
   c_duty_applied: cover property ($changed(duty_value) && st_r.duty_app != 12'h000);
   c_heavy_smoothing_strength: cover property (smoothing_strength_code == 2'b11 && tick && st_r.ramping);
endmodule
`default_nettype wire

// ### tb/bbrc_pwm_src.sv
// pwm brightness source model for the ramp control bench
`timescale 1ns/100ps
`default_nettype none
module bbrc_pwm_src (
   // sampling clock
   input  wire logic        clk,
   // period and high time in clock samples
   input  wire logic [15:0] per,
   input  wire logic [15:0] hi,
   // brightness pin
   output var  logic        pwm
);
   logic [15:0] cnt_r;   // position inside the period
   initial begin
      cnt_r = 16'h0000;
      pwm   = 1'b0;
   end
   // free-running period; the bench sets per and hi, so it picks the rate
   always @(posedge clk) begin
      if (cnt_r >= per - 16'h0001) cnt_r <= 16'h0000;
      else cnt_r <= cnt_r + 16'h0001;
      pwm <= (cnt_r < hi);   // high part first, so each period opens on a rise
   end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the brightness ramp control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, bl_on = 1'b0, auto = 1'b0, pwm;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [1:0] src = 2'h0, ov;
   logic [11:0] reg_br = 12'h000, duty, bright;
   logic [5:0] fault = 6'h00, drive;
   logic [15:0] per = 16'h0040, hi = 16'h0010;
   logic freq, ind, busy;
   logic [11:0] exp_q[$];   // expected values, oldest first
   logic [2:0] sel_q[$];    // which output each note is about
   int bad_count = 0, samples_checked = 0;
   logic [31:0] rv;
   always #25 clk = ~clk;
   bbrc_pwm_src u_bbrc_pwm_src (.clk(clk), .per(per), .hi(hi), .pwm(pwm));
   bbrc_top u_bbrc_top (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rdata(reg_rdata), .nv_boost_config(8'h01),
      .brightness_source_select(src), .reg_brightness(reg_br), .backlight_on(bl_on),
      .auto_detect(auto), .string_fault(fault), .pwm_in(pwm),
      .boost_switch_freq_select(freq), .inductor_range(ind),
      .string_overvoltage_level(ov), .string_drive(drive), .duty_value(duty),
      .brightness_level(bright), .ramp_busy(busy));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // output picked by a selector code
   function automatic logic [11:0] pick(input logic [2:0] s);
      case (s)
         3'h0: pick = {4'h0, reg_rdata};
         3'h1: pick = {11'h000, freq};
         3'h2: pick = {11'h000, ind};
         3'h3: pick = {10'h000, ov};
         3'h4: pick = {6'h00, drive};
         3'h5: pick = duty;
         3'h6: pick = bright;
         default: pick = {11'h000, busy};
      endcase
   endfunction
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // note an expectation; the monitor compares it at the next falling edge
   task automatic ex(input logic [2:0] s, input logic [11:0] v);
      sel_q.push_back(s);
      exp_q.push_back(v);
   endtask
   // one register write, strobe held for exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   // read data trails the address by one registered cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      ex(3'h0, {4'h0, e});
   endtask
   // bounded wait for an output value; running out ends the run
   task automatic wait_for(input logic [2:0] s, input logic [11:0] v, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge clk);
         if (pick(s) === v) break;
      end
      @(posedge clk);
      if (i == n) begin
         bad_count++;
         $display("unexpected at %0t: wait gave %h want %h", $time, pick(s), v);
         report_and_stop();
      end
      ex(s, v);
   endtask
   // monitor: take notes off the queue where outputs are settled
   always @(negedge clk) begin
      while (exp_q.size() > 0) begin
         logic [11:0] e, g;
         e = exp_q.pop_front();
         g = pick(sel_q.pop_front());
         samples_checked++;
         if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
         end
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(51));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(8'h13, 8'h01);
      rd(8'h14, 8'h00);
      rd(8'h15, 8'h00);
      ex(3'h1, 12'h001);
      wr(8'h13, 8'h02);
      wr(8'h20, 8'h5a);
      rd(8'h13, 8'h02);
      ex(3'h1, 12'h001);
      ex(3'h2, 12'h001);
      rd(8'h20, 8'h00);
      $display("test boost done");
      rv = $urandom;
      wr(8'h14, {2'b10, rv[5:0]});
      bl_on <= 1'b1;
      fault <= 6'h3f;
      repeat (3) @(posedge clk);
      ex(3'h3, 12'h002);
      ex(3'h4, {6'h00, rv[5:0]});
      auto <= 1'b1;
      fault <= 6'h05;
      repeat (3) @(posedge clk);
      fault <= 6'h00;
      repeat (3) @(posedge clk);
      ex(3'h4, {6'h00, rv[5:0] & 6'h3a});
      rd(8'h1e, {2'b00, rv[5:0] & 6'h05});
      bl_on <= 1'b0;
      repeat (3) @(posedge clk);
      ex(3'h4, 12'h000);
      $display("test strings done");
      wait_for(3'h5, 12'h400, 800);
      ex(3'h6, 12'h400);
      wr(8'h15, 8'h38);
      hi <= 16'h0011;
      repeat (600) @(posedge clk);
      ex(3'h5, 12'h400);
      wr(8'h15, 8'h30);
      wait_for(3'h5, 12'h440, 600);
      $display("test duty done");
      src <= 2'h1;
      reg_br <= rv[27:16] | 12'h800;
      repeat (2) @(posedge clk);
      ex(3'h6, rv[27:16] | 12'h800);
      src <= 2'h3;
      wr(8'h15, 8'h01);
      reg_br <= 12'h001;
      wait_for(3'h7, 12'h001, 10);
      repeat (2000) @(posedge clk);
      ex(3'h7, 12'h001);
      reg_br <= 12'hfff;
      repeat (1000) @(posedge clk);
      ex(3'h7, 12'h001);
      wr(8'h15, 8'h00);
      reg_br <= 12'h123;
      wait_for(3'h7, 12'h000, 20);
      $display("test ramp done");
      wr(8'h15, 8'hc0);
      reg_br <= 12'hfff;
      wait_for(3'h6, 12'h08c, 20);
      wait_for(3'h6, 12'h43f, 1000);
      src <= 2'h2;
      reg_br <= 12'h800;
      wait_for(3'h6, 12'h220, 1000);
      $display("test smoothing done");
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule
`default_nettype wire
